// [include/mcg_pkg.sv]
// Package for the motor current and gain readback register bank
package mcg_pkg;
	// Register offsets in the host register space
	localparam logic [11:0] SUPPLY_CURRENT_OFS = 12'h410;
	localparam logic [11:0] WINDING_A_OFS = 12'h440;
	localparam logic [11:0] WINDING_B_OFS = 12'h442;
	localparam logic [11:0] WINDING_C_OFS = 12'h444;
	localparam logic [11:0] GAIN_CODE_OFS = 12'h468;
	localparam logic [11:0] RANGE_CODE_OFS = 12'h472;
	// Values after reset
	localparam logic [31:0] CURRENT_RESET = 32'h0000_0000;
	localparam logic [15:0] CODE_RESET = 16'h0000;
	// Fixed-point format of current words
	localparam int CURRENT_FRAC_BITS = 27;
	localparam int FULL_SCALE_DIVISOR = 8;
	// Sense-amplifier gain codes
	typedef enum logic [15:0] {
		MCG_GAIN_X8 = 16'h0000,
		MCG_GAIN_X4 = 16'h0001,
		MCG_GAIN_X2 = 16'h0002,
		MCG_GAIN_X1 = 16'h0003
	} mcg_gain_t;
	// Voltage-sense range codes
	typedef enum logic [15:0] {
		MCG_RANGE_60V = 16'h0000,
		MCG_RANGE_30V = 16'h0001,
		MCG_RANGE_15V = 16'h0002
	} mcg_range_t;
	// Update bundle from the control algorithm
	typedef struct packed {
		logic supply_we;
		logic [31:0] supply;
		logic wind_a_we;
		logic [31:0] wind_a;
		logic wind_b_we;
		logic [31:0] wind_b;
		logic wind_c_we;
		logic [31:0] wind_c;
		logic gain_we;
		logic [15:0] sense_amp_gain_code;
		logic range_we;
		logic [15:0] range_code;
	} mcg_update_t;
	// Host register access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} mcg_req_t;
endpackage

// [core/mcg_readback.sv]
// Read-only bank of current and gain readback registers
//
// Summary of operation
// - Supply current read as signed 32-bit word, value/2^27 times full-scale/8.
// - Winding A current read as signed 32-bit word, same scaling.
// - Winding B current read as signed 32-bit word, same scaling.
// - Winding C current read as signed 32-bit word, same scaling.
// - Gain code 16-bit: 0 x8, 1 x4, 2 x2, 3 x1 lowest gain.
// - Range code 16-bit: 0 is 60V, 1 is 30V, 2 is 15V.
// - Gain readback clears to zero on reset, readable, not writable.
`timescale 1ns/1ps
module mcg_readback (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Internal updates from the control algorithm
	input mcg_pkg::mcg_update_t upd,
	// Host register port
	input mcg_pkg::mcg_req_t req,
	output logic rvalid,
	output logic [31:0] rdata,
	output logic hit,
	// Decoded codes for the control path
	output mcg_pkg::mcg_gain_t gain_code,
	output mcg_pkg::mcg_range_t range_code
);
	// Stored words
	logic [31:0] supply_current_readback;
	logic [31:0] winding_a_current_readback;
	logic [31:0] winding_b_current_readback;
	logic [31:0] winding_c_current_readback;
	logic [15:0] sense_amp_gain_readback;
	logic [15:0] volt_sense_range_readback;

	// Next values of the stored words
	logic [31:0] next_supply;
	logic [31:0] next_wind_a;
	logic [31:0] next_wind_b;
	logic [31:0] next_wind_c;
	logic [15:0] next_gain;
	logic [15:0] next_range;

	// Access decode
	logic is_read;
	logic is_access;
	logic sel_supply;
	logic sel_wind_a;
	logic sel_wind_b;
	logic sel_wind_c;
	logic sel_gain;
	logic sel_range;
	logic any_sel;

	// Response next values
	logic next_rvalid;
	logic next_hit;
	logic [31:0] next_rdata;

	// Address match against one register offset
	function automatic logic addr_is(input logic [11:0] a,
		input logic [11:0] ofs);
		addr_is = (a == ofs);
	endfunction

	// Short codes read back zero-extended
	function automatic logic [31:0] zext16(input logic [15:0] v);
		zext16 = {16'h0000, v};
	endfunction

	// Out-of-range gain codes saturate to unity gain
	function automatic logic [15:0] fix_gain(input logic [15:0] c);
		if (c > mcg_pkg::MCG_GAIN_X1) begin
			fix_gain = mcg_pkg::MCG_GAIN_X1;
		end else begin
			fix_gain = c;
		end
	endfunction

	// Range codes beyond the lowest range are not taken
	function automatic logic range_ok(input logic [15:0] c);
		range_ok = (c <= mcg_pkg::MCG_RANGE_15V);
	endfunction

	// Supply current next value
	always_comb begin
		next_supply = supply_current_readback;
		if (upd.supply_we) begin
			next_supply = upd.supply;
		end
	end

	// Supply current word, signed two's complement
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			supply_current_readback <= mcg_pkg::CURRENT_RESET;
		end else begin
			supply_current_readback <= next_supply;
		end
	end

	// Winding A next value
	always_comb begin
		next_wind_a = winding_a_current_readback;
		if (upd.wind_a_we) begin
			next_wind_a = upd.wind_a;
		end
	end

	// Winding A current word
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			winding_a_current_readback <= mcg_pkg::CURRENT_RESET;
		end else begin
			winding_a_current_readback <= next_wind_a;
		end
	end

	// Winding B next value
	always_comb begin
		next_wind_b = winding_b_current_readback;
		if (upd.wind_b_we) begin
			next_wind_b = upd.wind_b;
		end
	end

	// Winding B current word
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			winding_b_current_readback <= mcg_pkg::CURRENT_RESET;
		end else begin
			winding_b_current_readback <= next_wind_b;
		end
	end

	// Winding C next value
	always_comb begin
		next_wind_c = winding_c_current_readback;
		if (upd.wind_c_we) begin
			next_wind_c = upd.wind_c;
		end
	end

	// Winding C current word
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			winding_c_current_readback <= mcg_pkg::CURRENT_RESET;
		end else begin
			winding_c_current_readback <= next_wind_c;
		end
	end

	// Gain code next value
	always_comb begin
		next_gain = sense_amp_gain_readback;
		if (upd.gain_we) begin
			next_gain = fix_gain(upd.sense_amp_gain_code);
		end
	end

	// Gain code, internal update only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sense_amp_gain_readback <= mcg_pkg::CODE_RESET;
		end else begin
			sense_amp_gain_readback <= next_gain;
		end
	end

	// Range code next value
	always_comb begin
		next_range = volt_sense_range_readback;
		if (upd.range_we && range_ok(upd.range_code)) begin
			next_range = upd.range_code;
		end
	end

	// Range code, internal update only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			volt_sense_range_readback <= mcg_pkg::CODE_RESET;
		end else begin
			volt_sense_range_readback <= next_range;
		end
	end

	// Live views of the codes
	assign gain_code = mcg_pkg::mcg_gain_t'(sense_amp_gain_readback);
	assign range_code = mcg_pkg::mcg_range_t'(volt_sense_range_readback);

	// Access decode; read with write counts as a write
	always_comb begin
		is_access = req.rd | req.wr;
		is_read = req.rd & ~req.wr;
	end

	// Register selects
	always_comb begin
		sel_supply = addr_is(req.addr, mcg_pkg::SUPPLY_CURRENT_OFS);
		sel_wind_a = addr_is(req.addr, mcg_pkg::WINDING_A_OFS);
		sel_wind_b = addr_is(req.addr, mcg_pkg::WINDING_B_OFS);
		sel_wind_c = addr_is(req.addr, mcg_pkg::WINDING_C_OFS);
		sel_gain = addr_is(req.addr, mcg_pkg::GAIN_CODE_OFS);
		sel_range = addr_is(req.addr, mcg_pkg::RANGE_CODE_OFS);
		any_sel = sel_supply | sel_wind_a | sel_wind_b;
		any_sel = any_sel | sel_wind_c | sel_gain | sel_range;
	end

	// Read data mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (sel_supply) begin
			next_rdata = supply_current_readback;
		end
		if (sel_wind_a) begin
			next_rdata = winding_a_current_readback;
		end
		if (sel_wind_b) begin
			next_rdata = winding_b_current_readback;
		end
		if (sel_wind_c) begin
			next_rdata = winding_c_current_readback;
		end
		if (sel_gain) begin
			next_rdata = zext16(sense_amp_gain_readback);
		end
		if (sel_range) begin
			next_rdata = zext16(volt_sense_range_readback);
		end
	end

	// Response next values; writes never reach storage
	always_comb begin
		next_rvalid = is_access;
		next_hit = is_access & any_sel;
	end

	// Valid flag, one cycle after the request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid <= 1'b0;
		end else begin
			rvalid <= next_rvalid;
		end
	end

	// Mapped flag, alongside the valid flag
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hit <= 1'b0;
		end else begin
			hit <= next_hit;
		end
	end

	// Read data, held until the next request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= mcg_pkg::CURRENT_RESET;
		end else if (is_read) begin
			rdata <= next_rdata;
		end else if (is_access) begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule

// [sim/mcg_readback_chk.sv]
// Assertion checker for the readback bank
`timescale 1ns/1ps
module mcg_readback_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Watched ports
	input mcg_pkg::mcg_update_t upd,
	input mcg_pkg::mcg_req_t req,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic hit,
	input mcg_pkg::mcg_gain_t gain_code,
	input mcg_pkg::mcg_range_t range_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_rd(a);
		req.rd && !req.wr && req.addr == a;
	endsequence
	a_sup_hit: assert property (s_rd(12'h410) |=> hit && rvalid)
		else $error("supply read");
	a_wa_data: assert property (upd.wind_a_we ##1 s_rd(12'h440) ##0
		!upd.wind_a_we |=> rdata == $past(upd.wind_a, 2)) else $error("wind a");
	a_wb_hit: assert property (s_rd(12'h442) |=> hit)
		else $error("wind b");
	a_wc_hit: assert property (s_rd(12'h444) |=> hit && rvalid)
		else $error("wind c");
	a_gain_upd: assert property (upd.gain_we
		&& upd.sense_amp_gain_code <= 16'h0003
		|=> gain_code == $past(upd.sense_amp_gain_code))
		else $error("gain update");
	a_range_upd: assert property (upd.range_we
		&& upd.range_code <= 16'h0002
		|=> range_code == $past(upd.range_code)) else $error("range");
	a_gain_read: assert property (s_rd(12'h468) ##0 !upd.gain_we
		|=> rdata == {16'h0000, gain_code}) else $error("gain read");
	a_wr_ignored: assert property (req.wr && !upd.gain_we
		|=> rvalid && rdata == 32'h0 && $stable(gain_code))
		else $error("write taken");
endmodule
bind mcg_readback mcg_readback_chk u_chk (.clk(clk), .arst_n(arst_n),
	.upd(upd), .req(req), .rvalid(rvalid), .rdata(rdata), .hit(hit),
	.gain_code(gain_code), .range_code(range_code));

// [sim/mcg_readback_tb.sv]
// Self-checking bench for the readback bank
`timescale 1ns/1ps
module mcg_readback_tb;
	logic clk = 0;
	logic arst_n = 0;
	logic rvalid, hit;
	logic [31:0] rdata;
	mcg_pkg::mcg_update_t upd = '0;
	mcg_pkg::mcg_req_t req = '0;
	mcg_pkg::mcg_gain_t gain_code;
	mcg_pkg::mcg_range_t range_code;
	int error_cnt = 0;
	int n_compared = 0;
	mcg_readback u_dut (.clk(clk), .arst_n(arst_n), .upd(upd), .req(req),
		.rvalid(rvalid), .rdata(rdata), .hit(hit), .gain_code(gain_code),
		.range_code(range_code));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// One host access; writes answer with zero data
	task automatic acc(logic w, logic [11:0] a, logic [31:0] e, logic h);
		@(negedge clk);
		req = {~w, w, a, 32'hffff_ffff};
		@(negedge clk);
		req = '0;
		chk("ack", {30'h0, 1'b1, h}, {30'h0, rvalid, hit});
		chk("rdata", w ? 32'h0 : e, rdata);
	endtask
	task automatic results;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		arst_n = 1;
		acc(0, 12'h468, 32'h0, 1);
		upd = {1'b1, 32'h8000_0001, 1'b1, 32'hfff0_0002, 1'b1, 32'h7fff_ffff,
			1'b1, 32'h0000_0010, 1'b1, 16'h0002, 1'b1, 16'h0001};
		@(negedge clk);
		upd = '0;
		for (int i = 0; i < 3; i++) begin
			acc(i == 1, 12'h410, 32'h8000_0001, 1);
			acc(i == 1, 12'h440, 32'hfff0_0002, 1);
			acc(i == 1, 12'h442, 32'h7fff_ffff, 1);
			acc(i == 1, 12'h444, 32'h0000_0010, 1);
			acc(i == 1, 12'h468, 32'h0000_0002, 1);
			acc(i == 1, 12'h472, 32'h0000_0001, 1);
		end
		// Read right after an update sees the new word
		@(negedge clk);
		upd.wind_a_we = 1;
		upd.wind_a = 32'h1234_5678;
		@(negedge clk);
		upd = '0;
		req = {1'b1, 1'b0, 12'h440, 32'h0000_0000};
		@(negedge clk);
		req = '0;
		chk("wind a fresh", 32'h1234_5678, rdata);
		acc(0, 12'h412, 32'h0, 0);
		for (int c = 0; c < 4; c++) begin
			upd.gain_we = 1;
			upd.sense_amp_gain_code = 16'(c);
			upd.range_we = c < 3;
			upd.range_code = 16'(c);
			@(negedge clk);
			upd = '0;
			chk("range", 32'(c < 3 ? c : 2), 32'(range_code));
			chk("gain", 32'(c), 32'(gain_code));
			acc(0, 12'h468, 32'(c), 1);
		end
		arst_n = 0;
		@(negedge clk);
		arst_n = 1;
		acc(0, 12'h468, 32'h0, 1);
		acc(0, 12'h410, 32'h0, 1);
		// Out-of-range codes: gain saturates, range update dropped
		upd.gain_we = 1;
		upd.sense_amp_gain_code = 16'h0007;
		upd.range_we = 1;
		upd.range_code = 16'h0003;
		@(negedge clk);
		upd = '0;
		chk("gain sat", 32'h0000_0003, 32'(gain_code));
		chk("range kept", 32'h0000_0000, 32'(range_code));
		results;
	end
endmodule
